// *** cfb_router.sv ***
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ns
`include "cfb_params.svh"
module cfb_router
  import cfb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic msg_accept,
  input wire logic [1:0] msg_filter,
  output logic route_valid,
  output logic route_to_fifo,
  output logic [3:0] route_buffer,
  output logic [1:0] route_filter
);
  // ==========================================================
  // State
  cfb_regs_t r;
  cfb_regs_t next_r;
  cfb_dest_t sel_dest;
  logic dec_fifo;
  logic [3:0] dec_index;
  logic wr_en;
  logic rd_en;
  logic addr_hit;
  cfb_dest_t fil_dest [`CFB_NUM_FILTERS];
  logic fil_fifo [`CFB_NUM_FILTERS];
  logic [3:0] fil_index [`CFB_NUM_FILTERS];
  logic sel_write;
  logic cnt_clear;

  // Field of one filter from the select register
  function automatic cfb_dest_t field_of(input logic [15:0] reg_val, input logic [1:0] filt);
    cfb_dest_t f;
    f = `CFB_DEST_NONE;
    case (filt)
      `CFB_SEL_F12: f = reg_val[`CFB_F12_LSB +: `CFB_FIELD_W];
      `CFB_SEL_F13: f = reg_val[`CFB_F13_LSB +: `CFB_FIELD_W];
      `CFB_SEL_F14: f = reg_val[`CFB_F14_LSB +: `CFB_FIELD_W];
      `CFB_SEL_F15: f = reg_val[`CFB_F15_LSB +: `CFB_FIELD_W];
      default: f = `CFB_DEST_NONE;
    endcase
    return f;
  endfunction : field_of

  // Address decode
  function automatic logic is_mapped(input logic [11:0] a);
    return (a == `CFB_ADDR_SELECT) || (a == `CFB_ADDR_ROUTE_STATUS) || (a == `CFB_ADDR_ROUTE_COUNT);
  endfunction : is_mapped

  // ==========================================================
  // Field selection and decode
  assign sel_dest = field_of(r.filter_12_15_buffer_select, msg_filter);

  // Per-filter decode, one decoder for each destination field
  for (genvar g = 0; g < `CFB_NUM_FILTERS; g++) begin : g_filter
    // Field of this filter, fixed at elaboration
    assign fil_dest[g] = field_of(r.filter_12_15_buffer_select, 2'(g));
    cfb_dest_decode u_decode (
      .dest(fil_dest[g]),
      .to_fifo(fil_fifo[g]),
      .buffer_index(fil_index[g])
    );
  end

  // The accepting filter picks its own decoded destination
  assign dec_fifo = fil_fifo[msg_filter];
  assign dec_index = fil_index[msg_filter];

  // APB strobes; zero wait states
  assign addr_hit = is_mapped(paddr);
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign sel_write = wr_en && (paddr == `CFB_ADDR_SELECT);
  assign cnt_clear = wr_en && (paddr == `CFB_ADDR_ROUTE_COUNT) && pstrb[0];

  // Next state
  always_comb begin
    next_r = r;
    next_r.route_valid = 1'b0;
    case (r.state)
      cfb_idle: begin
        if (msg_accept) begin
          next_r.state = cfb_route;
        end
      end
      cfb_route: begin
        if (!msg_accept) begin
          next_r.state = cfb_idle;
        end
      end
      default: begin
        next_r.state = cfb_idle;
      end
    endcase
    // Capture the route at acceptance time
    if (msg_accept) begin
      next_r.route_valid = 1'b1;
      next_r.route_to_fifo = dec_fifo;
      next_r.route_buffer = dec_index;
      next_r.route_filter = msg_filter;
      next_r.route_count = r.route_count + 16'h0001;
    end
    // Register write with byte lanes
    if (sel_write) begin
      if (pstrb[0]) begin
        next_r.filter_12_15_buffer_select[7:0] = pwdata[7:0];
      end
      if (pstrb[1]) begin
        next_r.filter_12_15_buffer_select[15:8] = pwdata[15:8];
      end
    end
    if (cnt_clear) begin
      next_r.route_count = 16'h0000;
    end
    // Read data captured in setup phase
    if (rd_en) begin
      case (paddr)
        `CFB_ADDR_SELECT: next_r.prdata = {16'h0000, r.filter_12_15_buffer_select};
        `CFB_ADDR_ROUTE_STATUS: next_r.prdata = {24'h000000, r.route_filter, r.route_to_fifo, 1'b0, r.route_buffer};
        `CFB_ADDR_ROUTE_COUNT: next_r.prdata = {16'h0000, r.route_count};
        default: next_r.prdata = 32'h00000000;
      endcase
    end
  end

  // Register the state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{state: cfb_idle, filter_12_15_buffer_select: `CFB_SELECT_RESET, route_valid: 1'b0,
             route_to_fifo: 1'b0, route_buffer: 4'h0, route_filter: `CFB_FIRST_FILTER,
             route_count: 16'h0000, prdata: 32'h00000000};
    end else begin
      r <= next_r;
    end
  end

  // Outputs
  assign prdata = r.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;
  assign route_valid = r.route_valid;
  assign route_to_fifo = r.route_to_fifo;
  assign route_buffer = r.route_buffer;
  assign route_filter = r.route_filter;

  // ==========================================================
  // Assertions
  // All-ones code routes to the FIFO
  a_fifo_code: assert property (@(posedge pclk) disable iff (!presetn)
    msg_accept && sel_dest == `CFB_DEST_FIFO |=> route_valid && route_to_fifo)
    else $error("All-ones destination did not route to FIFO");

  // FIFO routes carry buffer index zero
  a_fifo_index: assert property (@(posedge pclk) disable iff (!presetn)
    msg_accept && sel_dest == `CFB_DEST_FIFO |=> route_buffer == `CFB_DEST_NONE)
    else $error("FIFO route left a buffer index");

  // Other codes name the buffer with that index
  a_buffer_index: assert property (@(posedge pclk) disable iff (!presetn)
    msg_accept && sel_dest != `CFB_DEST_FIFO |=> route_valid && !route_to_fifo && route_buffer == $past(sel_dest))
    else $error("Buffer index does not match destination");

  // A buffer route never names index fifteen
  a_buffer_range: assert property (@(posedge pclk) disable iff (!presetn)
    !route_to_fifo |-> route_buffer != `CFB_DEST_FIFO)
    else $error("Buffer route outside buffer 0 to 14");

  // FIFO flag and buffer index stay consistent
  a_fifo_pair: assert property (@(posedge pclk) disable iff (!presetn)
    route_to_fifo |-> route_buffer == `CFB_DEST_NONE)
    else $error("FIFO flag with a buffer index");

  // Filter 15 takes bits 15 to 12
  a_f15_field: assert property (@(posedge pclk) disable iff (!presetn)
    msg_accept && msg_filter == `CFB_SEL_F15 |-> sel_dest == r.filter_12_15_buffer_select[`CFB_F15_MSB:`CFB_F15_LSB])
    else $error("Filter 15 field wrong");

  // Filter 14 takes bits 11 to 8
  a_f14_field: assert property (@(posedge pclk) disable iff (!presetn)
    msg_accept && msg_filter == `CFB_SEL_F14 |-> sel_dest == r.filter_12_15_buffer_select[`CFB_F14_MSB:`CFB_F14_LSB])
    else $error("Filter 14 field wrong");

  // Filter 13 takes bits 7 to 4
  a_f13_field: assert property (@(posedge pclk) disable iff (!presetn)
    msg_accept && msg_filter == `CFB_SEL_F13 |-> sel_dest == r.filter_12_15_buffer_select[`CFB_F13_MSB:`CFB_F13_LSB])
    else $error("Filter 13 field wrong");

  // Filter 12 takes bits 3 to 0
  a_f12_field: assert property (@(posedge pclk) disable iff (!presetn)
    msg_accept && msg_filter == `CFB_SEL_F12 |-> sel_dest == r.filter_12_15_buffer_select[`CFB_F12_MSB:`CFB_F12_LSB])
    else $error("Filter 12 field wrong");

  // Filter 15 route follows its field end to end
  a_f15_route: assert property (@(posedge pclk) disable iff (!presetn)
    msg_accept && msg_filter == `CFB_SEL_F15 |=>
      route_to_fifo == ($past(r.filter_12_15_buffer_select[`CFB_F15_MSB:`CFB_F15_LSB]) == `CFB_DEST_FIFO))
    else $error("Filter 15 route does not follow its field");

  // Filter 12 route follows its field end to end
  a_f12_route: assert property (@(posedge pclk) disable iff (!presetn)
    msg_accept && msg_filter == `CFB_SEL_F12 |=>
      route_to_fifo == ($past(r.filter_12_15_buffer_select[`CFB_F12_MSB:`CFB_F12_LSB]) == `CFB_DEST_FIFO))
    else $error("Filter 12 route does not follow its field");

  // Route names the filter that was accepted
  a_filter_capture: assert property (@(posedge pclk) disable iff (!presetn)
    msg_accept |=> route_filter == $past(msg_filter))
    else $error("Route filter differs from accepted filter");

  // Route holds between accepted messages
  a_route_hold: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 !$past(msg_accept) |-> $stable(route_buffer) && $stable(route_to_fifo))
    else $error("Route changed without an accepted message");

  // Valid only after an accept
  a_valid_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    route_valid |-> $past(msg_accept))
    else $error("Route valid without acceptance");

  // No accept, no valid on the next cycle
  a_valid_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !msg_accept |=> !route_valid)
    else $error("Route valid held without acceptance");

  // State enters route on an accept
  a_state_route: assert property (@(posedge pclk) disable iff (!presetn)
    msg_accept |=> r.state == cfb_route)
    else $error("State missed an accepted message");

  // State returns to idle without an accept
  a_state_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !msg_accept |=> r.state == cfb_idle)
    else $error("State stayed busy without acceptance");

  // Lane 0 write lands in the low byte
  a_lane0_write: assert property (@(posedge pclk) disable iff (!presetn)
    sel_write && pstrb[0] |=> r.filter_12_15_buffer_select[7:0] == $past(pwdata[7:0]))
    else $error("Low byte of select register not written");

  // Lane 1 write lands in the high byte
  a_lane1_write: assert property (@(posedge pclk) disable iff (!presetn)
    sel_write && pstrb[1] |=> r.filter_12_15_buffer_select[15:8] == $past(pwdata[15:8]))
    else $error("High byte of select register not written");

  // Select register changes only by a write
  a_select_keep: assert property (@(posedge pclk) disable iff (!presetn)
    !sel_write |=> $stable(r.filter_12_15_buffer_select))
    else $error("Select register changed without a write");

  // Read of the select register
  a_read_select: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && paddr == `CFB_ADDR_SELECT |=> prdata == {16'h0000, $past(r.filter_12_15_buffer_select)})
    else $error("Select register read data wrong");

  // Read of the route status word
  a_read_status: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && paddr == `CFB_ADDR_ROUTE_STATUS |=>
      prdata[`CFB_ST_BUF_LSB +: `CFB_FIELD_W] == $past(route_buffer) && prdata[`CFB_ST_FIFO_BIT] == $past(route_to_fifo)
      && prdata[`CFB_ST_FILT_LSB +: $bits(route_filter)] == $past(route_filter))
    else $error("Route status read data wrong");

  // Read of the route count
  a_read_count: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && paddr == `CFB_ADDR_ROUTE_COUNT |=> prdata == {16'h0000, $past(r.route_count)})
    else $error("Route count read data wrong");

  // Unmapped reads return zero
  a_read_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && !addr_hit |=> prdata == 32'h00000000)
    else $error("Unmapped read returned data");

  // Read data holds outside a read setup
  a_read_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !rd_en |=> $stable(prdata))
    else $error("Read data changed without a read");

  // Each accept adds one to the count
  a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
    msg_accept && !cnt_clear |=> r.route_count == $past(r.route_count) + 16'h0001)
    else $error("Route count did not step");

  // Clear wins over a same-cycle accept
  a_count_clear: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_clear |=> r.route_count == 16'h0000)
    else $error("Route count not cleared");

  // Count holds with neither accept nor clear
  a_count_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !msg_accept && !cnt_clear |=> $stable(r.route_count))
    else $error("Route count changed on its own");

endmodule : cfb_router

// *** cfb_params.svh ***
`ifndef CFB_PARAMS_SVH
`define CFB_PARAMS_SVH
// ==========================================================
// Register map
`define CFB_ADDR_SELECT 12'h000
`define CFB_ADDR_ROUTE_STATUS 12'h004
`define CFB_ADDR_ROUTE_COUNT 12'h008
`define CFB_ADDR_W 12
`define CFB_SELECT_RESET 16'h0000
// ==========================================================
// Field positions
`define CFB_F12_LSB 0
`define CFB_F13_LSB 4
`define CFB_F14_LSB 8
`define CFB_F15_LSB 12
`define CFB_FIELD_W 4
`define CFB_F12_MSB 3
`define CFB_F13_MSB 7
`define CFB_F14_MSB 11
`define CFB_F15_MSB 15
`define CFB_NUM_FILTERS 4
// ==========================================================
// Filter numbers on the accept interface
`define CFB_SEL_F12 2'h0
`define CFB_SEL_F13 2'h1
`define CFB_SEL_F14 2'h2
`define CFB_SEL_F15 2'h3
// ==========================================================
// Route status word layout
`define CFB_ST_BUF_LSB 0
`define CFB_ST_FIFO_BIT 5
`define CFB_ST_FILT_LSB 6
`define CFB_FIRST_FILTER 2'h0
`define CFB_DEST_FIFO 4'hf
`define CFB_DEST_NONE 4'h0
`endif

// *** cfb_pkg.sv ***
// ==========================================================
// Types for the filter 12-15 routing block
package cfb_pkg;
  typedef logic [3:0] cfb_dest_t;
  typedef enum logic [1:0] {
    cfb_idle,
    cfb_route
  } cfb_state_t;
  typedef struct packed {
    cfb_state_t state;
    logic [15:0] filter_12_15_buffer_select;
    logic route_valid;
    logic route_to_fifo;
    logic [3:0] route_buffer;
    logic [1:0] route_filter;
    logic [15:0] route_count;
    logic [31:0] prdata;
  } cfb_regs_t;
endpackage : cfb_pkg

// *** cfb_dest_decode.sv ***
`timescale 1ns/1ns
`include "cfb_params.svh"
// ==========================================================
// Destination field decoder: FIFO code or buffer index
module cfb_dest_decode
  import cfb_pkg::*;
(
  input wire logic [3:0] dest,
  output logic to_fifo,
  output logic [3:0] buffer_index
);
  // All ones selects the FIFO, others name buffer 0 to 14
  always_comb begin
    to_fifo = (dest == `CFB_DEST_FIFO);
    buffer_index = to_fifo ? `CFB_DEST_NONE : dest;
  end
endmodule : cfb_dest_decode

// *** cfb_msg_source.sv ***
`timescale 1ns/1ns
// ==========================================================
// Far side: hands accepted messages to the router
module cfb_msg_source (
  input wire logic pclk,
  output logic msg_accept,
  output logic [1:0] msg_filter
);
  initial begin
    msg_accept = 1'b0;
    msg_filter = 2'h0;
  end
  // One-cycle accept pulse; filter lines go to the inverse once released
  task send(input logic [1:0] f);
    @(posedge pclk);
    msg_accept <= 1'b1;
    msg_filter <= f;
    @(posedge pclk);
    msg_accept <= 1'b0;
    msg_filter <= ~f;
  endtask : send
endmodule : cfb_msg_source

// *** cfb_router_bench.sv ***
`timescale 1ns/1ns
`include "cfb_params.svh"
module cfb_router_bench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, sel, prdata;
  logic [3:0] pstrb = 4'hf, route_buffer;
  logic pready, pslverr, msg_accept, route_valid, route_to_fifo;
  logic [1:0] msg_filter, route_filter, f;
  int fail_count = 0, n_compared = 0;
  // ==========================================================
  // Clock, partner and design
  always #5 pclk = ~pclk;
  cfb_msg_source src (.pclk(pclk), .msg_accept(msg_accept), .msg_filter(msg_filter));
  cfb_router dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .msg_accept(msg_accept), .msg_filter(msg_filter), .route_valid(route_valid),
    .route_to_fifo(route_to_fifo), .route_buffer(route_buffer), .route_filter(route_filter));
  // ==========================================================
  // Report and verdict
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // APB transfer: setup, then access held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // ==========================================================
  // Test sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `CFB_ADDR_SELECT, 32'h0);
    chk("select reset", `CFB_SELECT_RESET, rd);
    $display("test reset done");
    // Every code, each filter in turn, other fields holding the opposite code
    for (int i = 0; i < 16; i++) begin
      f = 2'(i % 4);
      sel = {16'h0, {4{~i[3:0]}}};
      sel[f * 4 +: 4] = i[3:0];
      apb(1'b1, `CFB_ADDR_SELECT, sel);
      apb(1'b0, `CFB_ADDR_SELECT, 32'h0);
      chk("select readback", sel, rd);
      src.send(f);
      #1;
      chk("route_valid", 32'h1, route_valid);
      chk("route_to_fifo", (i == 15), route_to_fifo);
      chk("route_buffer", (i == 15) ? 0 : i, route_buffer);
      chk("route_filter", f, route_filter);
      @(posedge pclk);
      #1;
      chk("route_valid pulse", 32'h0, route_valid);
    end
    $display("test routing done");
    // A later write leaves the last route alone, next accept sees it
    apb(1'b1, `CFB_ADDR_SELECT, 32'h0000_2fff);
    chk("route_to_fifo held", 32'h1, route_to_fifo);
    src.send(2'h3);
    #1;
    chk("route_buffer new", 32'h2, route_buffer);
    $display("test sampling done");
    // Status and count of the last route, then the count clear
    apb(1'b0, `CFB_ADDR_ROUTE_STATUS, 32'h0);
    chk("route status", 32'h0000_00c2, rd);
    apb(1'b0, `CFB_ADDR_ROUTE_COUNT, 32'h0);
    chk("route count", 32'h0000_0011, rd);
    apb(1'b1, `CFB_ADDR_ROUTE_COUNT, 32'h0);
    apb(1'b0, `CFB_ADDR_ROUTE_COUNT, 32'h0);
    chk("count cleared", 32'h0, rd);
    $display("test status done");
    // Unmapped place: error, read zero, write ignored
    apb(1'b1, 12'h00c, 32'h0000_ffff);
    chk("pslverr write", 32'h1, err);
    apb(1'b0, 12'h00c, 32'h0);
    chk("pslverr read", 32'h1, err);
    chk("unmapped data", 32'h0, rd);
    apb(1'b0, `CFB_ADDR_SELECT, 32'h0);
    chk("select kept", 32'h0000_2fff, rd);
    $display("test unmapped done");
    // Byte lanes: each write touches only its own lane
    pstrb <= 4'h2;
    apb(1'b1, `CFB_ADDR_SELECT, 32'h0000_51ab);
    pstrb <= 4'h1;
    apb(1'b1, `CFB_ADDR_SELECT, 32'h0000_ab34);
    pstrb <= 4'hf;
    apb(1'b0, `CFB_ADDR_SELECT, 32'h0);
    chk("select lanes", 32'h0000_5134, rd);
    $display("test lanes done");
    // Reset in mid-run returns the route and the select register to reset values
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk("route_buffer reset", 32'h0, route_buffer);
    apb(1'b0, `CFB_ADDR_SELECT, 32'h0);
    chk("select reset again", `CFB_SELECT_RESET, rd);
    $display("test mid reset done");
    print_verdict();
  end
  // Overall run limit
  initial begin
    #200000;
    fail_count++;
    print_verdict();
  end
endmodule : cfb_router_bench
